// ---- logic/gtb_tape_block_framer.sv ----
// How it works
// - a write command with zero byte count is refused and writes nothing
// - reading, fifteen feet of blank tape stops motion and raises reject
// - end-of-tape is reported only; no operation is ever blocked by it
// - preamble is sixteen five-character control subgroups
// - terminator is 10101 at block start, 1010L with erased last char at end
// - second control subgroup is 01111 at start and 11110 at end
// - fourteen all-ones sync subgroups follow for oscillator lock
// - mark 1 is 00111 and aligns the five-character grouping on read
// - data group is seven data bytes then correction byte, split four and four
// - each track nibble is stored as a five-bit code and decoded back on read
// - after 158 groups, with more than six bytes left, insert a resync burst
// - mark 2 is 11100 on all tracks
// - end mark 11111 precedes the residual group
// - six or fewer bytes left form residual group, zero padded, aux check, correction
// - even group count adds a zero pad byte into the check, written first
// - check group holds six check copies (pad and five with even count), residual counter, correction byte
// - residual counter holds count modulo 32 high, real residual bytes low
// - postamble is the mirror image of preamble and mark 1
// - tape mark is all ones in zones 1 and 2, zone 3 erased, 250 to 400 changes
// - read detects a tape mark from enough contiguous zone-pattern characters
// - gap before a block is 0.3 inch, before a tape mark 3.3 inch
// - stored code follows the fixed sixteen-entry table
// - resync burst is mark 2, two sync subgroups, mark 1
`timescale 1ns/100ps
module gtb_tape_block_framer import gtb_pkg::*; #(
   parameter int unsigned CLK_HZ = 40_000_000,
   parameter int unsigned TAPE_IPS = 125,
   parameter int unsigned CHAR_CYC = CLK_HZ / (TAPE_IPS * FLUX_FCI),
   parameter int unsigned GAP_CYC = int'(64'(INTERBLOCK_SPACING_MIL) * CLK_HZ
                                          / (64'(TAPE_IPS) * 1000)),
   parameter int unsigned TM_GAP_CYC = int'(64'(TM_SPACING_MIL) * CLK_HZ
                                             / (64'(TAPE_IPS) * 1000)),
   parameter int unsigned MAX_GAP_CYC = int'(64'(MAX_SPACING_MIL) * CLK_HZ
                                              / (64'(TAPE_IPS) * 1000)),
   parameter int unsigned TM_SUBGROUPS = 65,
   parameter int unsigned TM_DETECT = 32
) (
   input wire logic clock_in,
   input wire logic rst_n_in,
   input wire logic cmd_valid_in,
   input wire gtb_cmd_req_t cmd_in,
   input wire logic [7:0] wr_data_in,
   input wire logic wr_valid_in,
   output logic wr_ready_out,
   input wire logic [8:0] rd_char_in,
   input wire logic rd_strobe_in,
   input wire logic gap_sense_in,
   input wire logic eot_sense_in,
   output logic [8:0] wr_char_out,
   output logic wr_strobe_out,
   output logic wr_gate_out,
   output logic motion_out,
   output logic [7:0] rd_data_out,
   output logic rd_valid_out,
   output gtb_status_t status_out
);
   typedef enum {W_IDLE, W_GAP, W_PRE, W_NEXT, W_FILL, W_SGB, W_RESYNC, W_CRC, W_POST,
                 W_TM} gtb_wst_t;
   typedef enum {R_OFF, R_HUNT, R_DATA, R_RES, R_CRC, R_OUT} gtb_rst_t;

   function automatic gtb_sg_t group_half(input logic [7:0][7:0] g, input logic hi);
      gtb_quad_t q;
      for (int k = 0; k < 4; k++) q[k] = with_par(g[hi ? k + 4 : k]);
      return sg_encode(q);
   endfunction : group_half

   // writer state
   gtb_wst_t wst_ff, nxt_wst;
   gtb_cmd_t wcmd_ff, nxt_wcmd;
   logic [6:0] step_ff, nxt_step;
   logic [31:0] gap_ff, nxt_gap;
   logic [15:0] rem_ff, nxt_rem, len_ff, nxt_len, tick_ff, nxt_tick;
   logic [2:0] fill_ff, nxt_fill, left_ff, nxt_left, resn_ff, nxt_resn;
   logic res_ff, nxt_res, crcph_ff, nxt_crcph, odd_ff, nxt_odd;
   logic [7:0] run_ff, nxt_run, crc_ff, nxt_crc;
   logic [7:0][7:0] grp_ff, nxt_grp;
   gtb_sg_t sg_ff, nxt_sg;
   logic [8:0] char_ff, nxt_char;
   logic stb_ff, nxt_stb, gate_ff, nxt_gate, rdy_ff, nxt_rdy, refused_ff, nxt_refused;
   logic busy_ff, nxt_busy;
   // reader state
   gtb_rst_t rst_ff, nxt_rst;
   logic [11:0] s1_ff, s2_ff;
   logic stb_d_ff, eot_ff;
   gtb_sg_t rsg_ff, nxt_rsg;
   logic [2:0] rpos_ff, nxt_rpos, ocnt_ff, nxt_ocnt, oidx_ff, nxt_oidx;
   logic rhalf_ff, nxt_rhalf;
   logic [7:0][7:0] rbuf_ff, nxt_rbuf;
   logic [7:0] odata_ff, nxt_odata;
   logic ovalid_ff, nxt_ovalid, motion_ff, nxt_motion, reject_ff, nxt_reject;
   logic tm_ff, nxt_tm, done_ff, nxt_done;
   logic [31:0] gapc_ff, nxt_gapc;
   logic [15:0] tmc_ff, nxt_tmc;

   logic idle_all, cmd_take, free, new_char, tm_like;
   logic [2:0] cap;
   logic [7:0] crcf;
   logic [7:0][7:0] g;
   gtb_quad_t q;
   gtb_sg_t sh;

   assign idle_all = (wst_ff == W_IDLE) && (left_ff == 3'h0) && (rst_ff == R_OFF);
   assign cmd_take = cmd_valid_in && idle_all;

   always_comb begin : w_next
      nxt_wst = wst_ff; nxt_wcmd = wcmd_ff; nxt_step = step_ff; nxt_gap = gap_ff;
      nxt_rem = rem_ff; nxt_len = len_ff; nxt_tick = tick_ff; nxt_fill = fill_ff;
      nxt_left = left_ff; nxt_resn = resn_ff; nxt_res = res_ff; nxt_crcph = crcph_ff;
      nxt_odd = odd_ff; nxt_run = run_ff; nxt_crc = crc_ff; nxt_grp = grp_ff;
      nxt_sg = sg_ff; nxt_char = char_ff; nxt_stb = 1'b0; nxt_refused = refused_ff;
      g = grp_ff;
      crcf = crc_ff;
      free = (left_ff == 3'h0);
      cap = res_ff ? RES_DATA : GROUP_DATA;
      // character emitter: one stored character per character time
      if (!free) begin
         if (tick_ff == 16'h0000) begin
            nxt_char = sg_ff[3'(SG_CHARS - left_ff)];
            nxt_stb = 1'b1;
            nxt_left = left_ff - 3'h1;
            nxt_tick = 16'(CHAR_CYC - 1);
         end else begin
            nxt_tick = tick_ff - 16'h0001;
         end
      end
      case (wst_ff)
         W_IDLE: begin
            if (cmd_take && cmd_in.cmd != CMD_READ) begin
               nxt_wcmd = cmd_in.cmd;
               nxt_refused = 1'b0;
               nxt_step = 7'h00;
               nxt_gap = (cmd_in.cmd == CMD_TAPE_MARK) ? 32'(TM_GAP_CYC - 1)
                                                       : 32'(GAP_CYC - 1);
               nxt_rem = cmd_in.len;
               nxt_len = cmd_in.len;
               if (cmd_in.cmd == CMD_WRITE && cmd_in.len == 16'h0000) begin
                  nxt_refused = 1'b1;
               end else begin
                  nxt_wst = W_GAP;
               end
            end
         end
         W_GAP: begin
            if (gap_ff == 32'h0) begin
               case (wcmd_ff)
                  CMD_WRITE: nxt_wst = W_PRE;
                  CMD_TAPE_MARK: nxt_wst = W_TM;
                  default: nxt_wst = W_IDLE;
               endcase
            end else begin
               nxt_gap = gap_ff - 32'h1;
            end
         end
         W_PRE: if (free) begin
            nxt_sg = ctrl_sg(pre_pat(step_ff[4:0]));
            nxt_left = SG_CHARS;
            nxt_tick = 16'h0000;
            nxt_step = step_ff + 7'h01;
            if (step_ff == PRE_LAST_STEP) begin
               nxt_wst = W_NEXT;
               nxt_run = 8'h00; nxt_odd = 1'b0; nxt_crc = 8'h00; nxt_crcph = 1'b0;
            end
         end
         W_NEXT: begin
            if (rem_ff > RES_LIMIT) begin
               if (run_ff == MAX_RUN_GROUPS) begin
                  nxt_wst = W_RESYNC;
                  nxt_step = 7'h00;
                  nxt_run = 8'h00;
               end else begin
                  nxt_wst = W_FILL; nxt_res = 1'b0; nxt_fill = 3'h0;
               end
            end else if (free) begin
               nxt_sg = ctrl_sg(PAT_END_MARK);
               nxt_left = SG_CHARS;
               nxt_tick = 16'h0000;
               nxt_wst = W_FILL; nxt_res = 1'b1; nxt_fill = 3'h0;
               nxt_resn = rem_ff[2:0];
            end
         end
         W_RESYNC: if (free) begin
            case (step_ff[1:0])
               2'h0: nxt_sg = ctrl_sg(PAT_MARK2);
               2'h3: nxt_sg = ctrl_sg(PAT_MARK1);
               default: nxt_sg = ctrl_sg(PAT_SYNC);
            endcase
            nxt_left = SG_CHARS;
            nxt_tick = 16'h0000;
            nxt_step = step_ff + 7'h01;
            if (step_ff == RESYNC_LAST_STEP) begin
               nxt_wst = W_FILL; nxt_res = 1'b0; nxt_fill = 3'h0;
            end
         end
         W_FILL: begin
            if (fill_ff < cap) begin
               if (rem_ff != 16'h0000) begin
                  if (wr_valid_in && rdy_ff) begin
                     nxt_grp[fill_ff] = wr_data_in;
                     nxt_crc = crc_step(crc_ff, wr_data_in);
                     nxt_rem = rem_ff - 16'h0001;
                     nxt_fill = fill_ff + 3'h1;
                  end
               end else begin
                  nxt_grp[fill_ff] = 8'h00;
                  nxt_fill = fill_ff + 3'h1;
               end
            end else if (free) begin
               if (res_ff) g[6] = crc_ff ^ AUX_XOR;
               g[7] = ecc7(g[6:0]);
               nxt_grp = g;
               nxt_sg = group_half(g, 1'b0);
               nxt_left = SG_CHARS;
               nxt_tick = 16'h0000;
               nxt_odd = ~odd_ff;
               if (!res_ff) nxt_run = run_ff + 8'h01;
               nxt_wst = W_SGB;
            end
         end
         W_SGB: if (free) begin
            nxt_sg = group_half(grp_ff, 1'b1);
            nxt_left = SG_CHARS;
            nxt_tick = 16'h0000;
            nxt_step = 7'h00;
            nxt_wst = crcph_ff ? W_POST : (res_ff ? W_CRC : W_NEXT);
         end
         W_CRC: if (free) begin
            // with an even group count a zero pad enters the check after the data bytes and is written first
            if (!odd_ff) crcf = crc_step(crc_ff, 8'h00);
            g[0] = odd_ff ? crcf : 8'h00;
            for (int i = 1; i < 6; i++) g[i] = crcf;
            g[6] = {len_ff[4:0], resn_ff};
            g[7] = ecc7(g[6:0]);
            nxt_grp = g;
            nxt_sg = group_half(g, 1'b0);
            nxt_left = SG_CHARS;
            nxt_tick = 16'h0000;
            nxt_res = 1'b0;
            nxt_crcph = 1'b1;
            nxt_wst = W_SGB;
         end
         W_POST: if (free) begin
            nxt_sg = ctrl_sg(rev5(pre_pat(5'(5'h10 - step_ff[4:0]))));
            if (step_ff == PRE_LAST_STEP) begin
               nxt_sg[4] = 9'h000;
               nxt_wst = W_IDLE;
            end
            nxt_left = SG_CHARS;
            nxt_tick = 16'h0000;
            nxt_step = step_ff + 7'h01;
         end
         W_TM: if (free) begin
            // 65 subgroups of 5 give 325 changes, inside the allowed window
            for (int k = 0; k < 5; k++) nxt_sg[k] = ZONE1 | ZONE2;
            nxt_left = SG_CHARS;
            nxt_tick = 16'h0000;
            nxt_step = step_ff + 7'h01;
            if (step_ff == 7'(TM_SUBGROUPS - 1)) nxt_wst = W_IDLE;
         end
         default: nxt_wst = W_IDLE;
      endcase
      nxt_rdy = (nxt_wst == W_FILL) && (nxt_fill < (nxt_res ? RES_DATA : GROUP_DATA))
                && (nxt_rem != 16'h0000);
      nxt_gate = (nxt_left != 3'h0);
   end

   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         wst_ff <= W_IDLE; wcmd_ff <= CMD_WRITE; step_ff <= '0; gap_ff <= '0;
         rem_ff <= '0; len_ff <= '0; tick_ff <= '0; fill_ff <= '0; left_ff <= '0;
         resn_ff <= '0; res_ff <= 1'b0; crcph_ff <= 1'b0; odd_ff <= 1'b0;
         run_ff <= '0; crc_ff <= '0; grp_ff <= '0; sg_ff <= '0; char_ff <= '0;
         stb_ff <= 1'b0; gate_ff <= 1'b0; rdy_ff <= 1'b0; refused_ff <= 1'b0;
      end else begin
         wst_ff <= nxt_wst; wcmd_ff <= nxt_wcmd; step_ff <= nxt_step; gap_ff <= nxt_gap;
         rem_ff <= nxt_rem; len_ff <= nxt_len; tick_ff <= nxt_tick; fill_ff <= nxt_fill;
         left_ff <= nxt_left; resn_ff <= nxt_resn; res_ff <= nxt_res;
         crcph_ff <= nxt_crcph; odd_ff <= nxt_odd; run_ff <= nxt_run; crc_ff <= nxt_crc;
         grp_ff <= nxt_grp; sg_ff <= nxt_sg; char_ff <= nxt_char; stb_ff <= nxt_stb;
         gate_ff <= nxt_gate; rdy_ff <= nxt_rdy; refused_ff <= nxt_refused;
      end
   end

   // drive pins: {eot, gap, strobe, char} through two flops first
   assign new_char = s2_ff[9] && !stb_d_ff;
   assign sh = {s2_ff[8:0], rsg_ff[4:1]};
   assign tm_like = (((s2_ff[8:0] & ZONE1) == ZONE1) || ((s2_ff[8:0] & ZONE2) == ZONE2))
                    && ((s2_ff[8:0] & ZONE3) == 9'h000);
   assign q = sg_decode(sh);

   always_comb begin : r_next
      nxt_rst = rst_ff; nxt_rsg = rsg_ff; nxt_rpos = rpos_ff; nxt_rhalf = rhalf_ff;
      nxt_rbuf = rbuf_ff; nxt_ocnt = ocnt_ff; nxt_oidx = oidx_ff; nxt_odata = odata_ff;
      nxt_ovalid = 1'b0; nxt_motion = motion_ff; nxt_reject = reject_ff;
      nxt_tm = 1'b0; nxt_done = 1'b0; nxt_gapc = gapc_ff;
      nxt_tmc = tmc_ff;
      nxt_busy = !(nxt_wst == W_IDLE && nxt_left == 3'h0);
      if (ocnt_ff != 3'h0) begin
         nxt_odata = rbuf_ff[oidx_ff];
         nxt_ovalid = 1'b1;
         nxt_oidx = oidx_ff + 3'h1;
         nxt_ocnt = ocnt_ff - 3'h1;
      end
      if (rst_ff == R_OFF) begin
         if (cmd_take && cmd_in.cmd == CMD_READ) begin
            nxt_rst = R_HUNT; nxt_motion = 1'b1; nxt_reject = 1'b0;
            nxt_gapc = 32'h0; nxt_tmc = 16'h0000;
         end
      end else begin
         if (new_char) begin
            nxt_rsg = sh;
            nxt_rpos = (rpos_ff == SG_LAST_POS) ? 3'h0 : rpos_ff + 3'h1;
            nxt_tmc = tm_like ? tmc_ff + 16'h0001 : 16'h0000;
         end
         case (rst_ff)
            R_HUNT: if (new_char && sh == ctrl_sg(PAT_MARK1)) begin
               nxt_rst = R_DATA; nxt_rpos = 3'h0; nxt_rhalf = 1'b0;
            end
            R_DATA, R_RES, R_CRC: if (new_char && rpos_ff == SG_LAST_POS) begin
               nxt_rhalf = ~rhalf_ff;
               if (rst_ff == R_DATA && sh == ctrl_sg(PAT_END_MARK)) begin
                  nxt_rst = R_RES; nxt_rhalf = 1'b0;
               end else if (rst_ff == R_DATA && sh == ctrl_sg(PAT_MARK2)) begin
                  nxt_rst = R_HUNT;
               end else if (rst_ff != R_CRC) begin
                  for (int k = 0; k < 4; k++) nxt_rbuf[rhalf_ff ? k + 4 : k] = q[k][7:0];
                  if (rhalf_ff && rst_ff == R_DATA) begin
                     nxt_ocnt = GROUP_DATA; nxt_oidx = 3'h0;
                  end
                  if (rhalf_ff && rst_ff == R_RES) nxt_rst = R_CRC;
               end else if (rhalf_ff) begin
                  nxt_ocnt = (q[X_POS_IN_B][2:0] > RES_DATA) ? RES_DATA
                                                             : q[X_POS_IN_B][2:0];
                  nxt_oidx = 3'h0;
                  nxt_rst = R_OUT;
               end
            end
            R_OUT: if (ocnt_ff == 3'h0) begin
               nxt_rst = R_OFF; nxt_motion = 1'b0; nxt_done = 1'b1;
            end
            default: nxt_rst = R_OFF;
         endcase
         // blank tape counts in every reader state until the reader stops
         nxt_gapc = s2_ff[10] ? gapc_ff + 32'h1 : 32'h0;
         if (gapc_ff == 32'(MAX_GAP_CYC - 1)) begin
            nxt_rst = R_OFF; nxt_motion = 1'b0; nxt_reject = 1'b1;
         end else if (tmc_ff == 16'(TM_DETECT)) begin
            nxt_rst = R_OFF; nxt_motion = 1'b0; nxt_tm = 1'b1;
         end
      end
      if (nxt_rst != R_OFF) nxt_busy = 1'b1;
   end

   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rst_ff <= R_OFF; s1_ff <= '0; s2_ff <= '0; stb_d_ff <= 1'b0; eot_ff <= 1'b0;
         rsg_ff <= '0; rpos_ff <= '0; rhalf_ff <= 1'b0; rbuf_ff <= '0; ocnt_ff <= '0;
         oidx_ff <= '0; odata_ff <= '0; ovalid_ff <= 1'b0; motion_ff <= 1'b0;
         reject_ff <= 1'b0; tm_ff <= 1'b0; done_ff <= 1'b0; gapc_ff <= '0;
         tmc_ff <= '0; busy_ff <= 1'b0;
      end else begin
         s1_ff <= {eot_sense_in, gap_sense_in, rd_strobe_in, rd_char_in};
         s2_ff <= s1_ff;
         stb_d_ff <= s2_ff[9];
         eot_ff <= s2_ff[11];
         rst_ff <= nxt_rst; rsg_ff <= nxt_rsg; rpos_ff <= nxt_rpos; rhalf_ff <= nxt_rhalf;
         rbuf_ff <= nxt_rbuf; ocnt_ff <= nxt_ocnt; oidx_ff <= nxt_oidx;
         odata_ff <= nxt_odata; ovalid_ff <= nxt_ovalid; motion_ff <= nxt_motion;
         reject_ff <= nxt_reject; tm_ff <= nxt_tm; done_ff <= nxt_done;
         gapc_ff <= nxt_gapc; tmc_ff <= nxt_tmc; busy_ff <= nxt_busy;
      end
   end

   assign wr_ready_out = rdy_ff;
   assign wr_char_out = char_ff;
   assign wr_strobe_out = stb_ff;
   assign wr_gate_out = gate_ff;
   assign motion_out = motion_ff;
   assign rd_data_out = odata_ff;
   assign rd_valid_out = ovalid_ff;
   assign status_out = '{busy: busy_ff, refused: refused_ff, reject: reject_ff,
                         eot: eot_ff, tape_mark: tm_ff, rec_done: done_ff};
endmodule : gtb_tape_block_framer

// ---- logic/gtb_pkg.sv ----
package gtb_pkg;
   // tape geometry, in thousandths of an inch unless stated
   localparam int unsigned INTERBLOCK_SPACING_MIL = 300;
   localparam int unsigned TM_SPACING_MIL = 3300;
   localparam int unsigned MAX_SPACING_MIL = 180000;
   localparam int unsigned FLUX_FCI = 9042;
   localparam int unsigned TM_FLUX_MIN = 250;
   localparam int unsigned TM_FLUX_MAX = 400;
   // serial five-bit control patterns, first bit in bit 4
   localparam logic [4:0] PAT_TERM = 5'h15;
   localparam logic [4:0] PAT_SECOND = 5'h0F;
   localparam logic [4:0] PAT_SYNC = 5'h1F;
   localparam logic [4:0] PAT_MARK1 = 5'h07;
   localparam logic [4:0] PAT_MARK2 = 5'h1C;
   localparam logic [4:0] PAT_END_MARK = 5'h1F;
   localparam logic [6:0] PRE_LAST_STEP = 7'h10;
   localparam logic [6:0] RESYNC_LAST_STEP = 7'h03;
   localparam logic [7:0] MAX_RUN_GROUPS = 8'h9E;
   localparam logic [2:0] GROUP_DATA = 3'h7;
   localparam logic [2:0] RES_DATA = 3'h6;
   localparam logic [15:0] RES_LIMIT = 16'h0006;
   localparam logic [2:0] SG_CHARS = 3'h5;
   localparam logic [2:0] SG_LAST_POS = 3'h4;
   localparam logic [2:0] X_POS_IN_B = 3'h2;
   localparam logic [7:0] AUX_XOR = 8'hFF;
   // zone track masks, track n in bit n-1
   localparam logic [8:0] ZONE1 = 9'h049;
   localparam logic [8:0] ZONE2 = 9'h092;
   localparam logic [8:0] ZONE3 = 9'h124;

   typedef enum logic [1:0] {CMD_WRITE, CMD_TAPE_MARK, CMD_GAP_ERASE, CMD_READ} gtb_cmd_t;
   typedef struct packed {
      gtb_cmd_t cmd;
      logic [15:0] len;
   } gtb_cmd_req_t;
   typedef struct packed {
      logic busy;
      logic refused;
      logic reject;
      logic eot;
      logic tape_mark;
      logic rec_done;
   } gtb_status_t;
   typedef logic [4:0][8:0] gtb_sg_t;
   typedef logic [3:0][8:0] gtb_quad_t;

   function automatic logic [8:0] with_par(input logic [7:0] b);
      return {~^b, b};
   endfunction : with_par

   function automatic logic [4:0] gcr_enc(input logic [3:0] n);
      logic [4:0] c;
      case (n)
         4'h0: c = 5'h19;
         4'h1: c = 5'h1B;
         4'h2: c = 5'h12;
         4'h3: c = 5'h13;
         4'h4: c = 5'h1D;
         4'h5: c = 5'h15;
         4'h6: c = 5'h16;
         4'h7: c = 5'h17;
         4'h8: c = 5'h1A;
         4'h9: c = 5'h09;
         4'hA: c = 5'h0A;
         4'hB: c = 5'h0B;
         4'hC: c = 5'h1E;
         4'hD: c = 5'h0D;
         4'hE: c = 5'h0E;
         default: c = 5'h0F;
      endcase
      return c;
   endfunction : gcr_enc

   // invalid codes decode as zero; nothing on read checks the group, so they pass through
   function automatic logic [3:0] gcr_dec(input logic [4:0] c);
      logic [3:0] n;
      n = 4'h0;
      for (int i = 0; i < 16; i++) begin
         if (gcr_enc(4'(i)) == c) n = 4'(i);
      end
      return n;
   endfunction : gcr_dec

   function automatic gtb_sg_t sg_encode(input gtb_quad_t q);
      gtb_sg_t s;
      logic [4:0] code;
      s = '0;
      for (int t = 0; t < 9; t++) begin
         code = gcr_enc({q[0][t], q[1][t], q[2][t], q[3][t]});
         for (int k = 0; k < 5; k++) s[k][t] = code[4-k];
      end
      return s;
   endfunction : sg_encode

   function automatic gtb_quad_t sg_decode(input gtb_sg_t s);
      gtb_quad_t q;
      logic [3:0] n;
      q = '0;
      for (int t = 0; t < 9; t++) begin
         n = gcr_dec({s[0][t], s[1][t], s[2][t], s[3][t], s[4][t]});
         for (int k = 0; k < 4; k++) q[k][t] = n[3-k];
      end
      return q;
   endfunction : sg_decode

   function automatic gtb_sg_t ctrl_sg(input logic [4:0] p);
      gtb_sg_t s;
      for (int k = 0; k < 5; k++) s[k] = {9{p[4-k]}};
      return s;
   endfunction : ctrl_sg

   function automatic logic [4:0] rev5(input logic [4:0] p);
      return {p[0], p[1], p[2], p[3], p[4]};
   endfunction : rev5

   function automatic logic [4:0] pre_pat(input logic [4:0] step);
      logic [4:0] p;
      case (step)
         5'h00: p = PAT_TERM;
         5'h01: p = PAT_SECOND;
         5'h10: p = PAT_MARK1;
         default: p = PAT_SYNC;
      endcase
      return p;
   endfunction : pre_pat

   // stand-ins for the standard check polynomials, kept behind one function each
   function automatic logic [7:0] crc_step(input logic [7:0] c, input logic [7:0] b);
      return {c[6:0], c[7]} ^ b;
   endfunction : crc_step

   function automatic logic [7:0] ecc7(input logic [6:0][7:0] d);
      logic [7:0] e;
      e = '0;
      for (int i = 0; i < 7; i++) e = {e[6:0], e[7]} ^ d[i];
      return e;
   endfunction : ecc7
endpackage : gtb_pkg

// ---- test/gtb_drive_model.sv ----
`timescale 1ns/100ps
// plays blank tape, or a tape mark while mode is high; clock still when stopped
module gtb_drive_model import gtb_pkg::*; (
   input wire logic clock_in,
   input wire logic motion_out,
   input wire logic mode,
   output logic [8:0] rd_char_in = 9'h000,
   output logic rd_strobe_in = 1'h0,
   output logic gap_sense_in = 1'h1
);
   logic [1:0] ph = 2'h0;
   always @(posedge clock_in) begin
      ph <= motion_out ? ph + 2'h1 : 2'h0;
      gap_sense_in <= !(motion_out && mode);
      rd_strobe_in <= motion_out && mode && ph == 2'h1;
      // idle lines keep moving so a stale value never decodes
      rd_char_in <= (motion_out && mode) ? 9'h0DB : ~rd_char_in;
   end
endmodule : gtb_drive_model

// ---- test/gtb_tape_block_framer_chk.sv ----
`timescale 1ns/100ps
module gtb_tape_block_framer_chk import gtb_pkg::*; (
   input wire logic clock_in,
   input wire logic rst_n_in,
   input wire logic cmd_valid_in,
   input wire gtb_cmd_req_t cmd_in,
   input wire logic eot_sense_in,
   input wire logic wr_ready_out,
   input wire logic wr_strobe_out,
   input wire logic motion_out,
   input wire gtb_status_t status_out
);
   default clocking @(posedge clock_in); endclocking
   default disable iff (!rst_n_in);
   a_zero_refused: assert property (
      cmd_valid_in && !status_out.busy && cmd_in.cmd == CMD_WRITE && cmd_in.len == 16'h0000
      |=> status_out.refused && !status_out.busy) else $error("empty write not refused");
   a_busy_take: assert property (
      cmd_valid_in && !status_out.busy && !(cmd_in.cmd == CMD_WRITE && cmd_in.len == 16'h0000)
      |=> status_out.busy) else $error("command not taken");
   a_strobe_pulse: assert property (wr_strobe_out |=> !wr_strobe_out)
      else $error("strobe longer than one cycle");
   a_eot_follow: assert property ($stable(eot_sense_in) [*5] |-> status_out.eot == eot_sense_in)
      else $error("end of tape not reported");
   a_ready_busy: assert property (wr_ready_out |-> status_out.busy)
      else $error("byte requested while idle");
   a_refused_holds: assert property (
      status_out.refused && !cmd_valid_in |=> status_out.refused) else $error("refused lost");
   a_mark_pulse: assert property (status_out.tape_mark |=> !status_out.tape_mark)
      else $error("tape mark flag not a pulse");
   a_reject_stop: assert property ($rose(status_out.reject) |-> ##[0:2] !motion_out)
      else $error("motion kept after long gap");
   a_idle_quiet: assert property (!status_out.busy && !cmd_valid_in |=> !wr_strobe_out)
      else $error("character written while idle");
endmodule : gtb_tape_block_framer_chk

// ---- test/gtb_tape_block_framer_tb.sv ----
`timescale 1ns/100ps
module gtb_tape_block_framer_tb;
   import gtb_pkg::*;
   logic clock_in = 1'h0, rst_n_in = 1'h0, cmd_valid_in = 1'h0, wr_valid_in = 1'h1;
   logic eot_sense_in = 1'h0, mode = 1'h0, tm, rv;
   gtb_cmd_req_t cmd_in = '0;
   logic [7:0] wr_data_in = 8'h00, rd_data_out;
   logic [8:0] rd_char_in, wr_char_out, ch [$];
   logic rd_strobe_in, gap_sense_in, wr_ready_out, wr_strobe_out, wr_gate_out;
   logic motion_out, rd_valid_out;
   gtb_status_t status_out;
   int miscompares = 0, checks = 0, gap;
   always #12.5 clock_in = ~clock_in;
   // short counts keep the run small; expectations use the same figures
   gtb_tape_block_framer #(.CHAR_CYC(4), .GAP_CYC(20), .TM_GAP_CYC(40), .MAX_GAP_CYC(200))
      dut (.*);
   gtb_drive_model drv (.*);
   task automatic chk(input logic ok, input string m);
      checks++;
      if (ok !== 1'h1) begin
         miscompares++;
         $display("MISMATCH %0t %s", $time, m);
      end
   endtask : chk
   task automatic complete_run;
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : complete_run
   task automatic run(input gtb_cmd_t c, input logic [15:0] n);
      int t;
      ch = {};
      gap = -1;
      tm = 1'h0;
      rv = 1'h0;
      @(posedge clock_in) cmd_in <= '{c, n};
      cmd_valid_in <= 1'h1;
      @(posedge clock_in) cmd_valid_in <= 1'h0;
      for (t = 0; t < 9000 && (t < 3 || status_out.busy || motion_out); t++) begin
         @(posedge clock_in) #1;
         tm |= status_out.tape_mark;
         rv |= rd_valid_out;
         if (wr_strobe_out && gap < 0) gap = t;
         if (wr_strobe_out) ch.push_back(wr_char_out);
      end
      if (t == 9000) begin
         chk(1'h0, "operation timed out");
         complete_run;
      end
   endtask : run
   function automatic logic [8:0] pre_ch(input int i);
      logic [4:0] p;
      p = i < 5 ? PAT_TERM : i < 10 ? PAT_SECOND : i < 80 ? PAT_SYNC : PAT_MARK1;
      return {9{p[4 - i % 5]}};
   endfunction : pre_ch
   task automatic t_refuse;
      run(CMD_WRITE, 16'h0000);
      chk(status_out.refused && !status_out.busy && ch.size() == 0, "empty write");
   endtask : t_refuse
   task automatic t_block;
      logic [8:0] res [5] = '{9'h0FF, 9'h1FF, 9'h100, 9'h100, 9'h1FF};
      @(posedge clock_in) eot_sense_in <= 1'h1;
      run(CMD_WRITE, 16'h0003);
      chk(ch.size() == 195 && gap >= 20 && status_out.eot, "block length or gap");
      for (int i = 0; i < 85; i++) chk(ch[i] === pre_ch(i), "preamble");
      for (int i = 85; i < 90; i++) chk(ch[i] === 9'h1FF, "end mark");
      for (int i = 0; i < 5; i++) chk(ch[90 + i] === res[i], "residual code");
      // postamble reads as the preamble backwards, last character erased
      for (int j = 0; j < 85; j++)
         chk(ch[110 + j] === (j == 84 ? 9'h000 : pre_ch(84 - j)), "postamble");
      @(posedge clock_in) eot_sense_in <= 1'h0;
   endtask : t_block
   task automatic t_mark;
      run(CMD_TAPE_MARK, 16'h0000);
      chk(ch.size() >= 250 && ch.size() <= 400 && gap >= 40, "tape mark size");
      foreach (ch[i]) chk(ch[i] === 9'h0DB, "tape mark zones");
      run(CMD_GAP_ERASE, 16'h0000);
      run(CMD_GAP_ERASE, 16'h0000);
      chk(ch.size() == 0 && !wr_gate_out, "gap erase wrote");
   endtask : t_mark
   task automatic t_read;
      mode <= 1'h1;
      run(CMD_READ, 16'h0000);
      chk(tm && !motion_out, "tape mark not seen");
      chk(!rv, "data delivered from a tape mark");
      mode <= 1'h0;
      run(CMD_READ, 16'h0000);
      chk(status_out.reject && !motion_out, "long gap not rejected");
   endtask : t_read
   initial begin
      repeat (4) @(posedge clock_in);
      rst_n_in <= 1'h1;
      t_refuse;
      t_block;
      t_mark;
      t_read;
      complete_run;
   end
endmodule : gtb_tape_block_framer_tb
bind gtb_tape_block_framer gtb_tape_block_framer_chk chk (.*);
